/* logic/rcs_pkg.sv */
// Purpose: constants for the timekeeper control/status block
// Assumes: byte-wide configuration access, 8-bit address
// Notes:   address groups decoded on address bits 7:3
package rcs_pkg;
   localparam int          RCS_CNT_W       = 40;
   localparam int          RCS_BYTES       = 5;
   localparam int          RCS_PRESC_W     = 7;
   // first advance on 64th edge, then every 128 edges
   localparam logic [6:0]  RCS_PRESC_FIRST = 7'h3F;

   localparam logic [7:0]  RCS_ADDR_CNT0   = 8'h40;
   localparam logic [7:0]  RCS_ADDR_MAT0   = 8'h48;
   localparam logic [7:0]  RCS_ADDR_MBIT0  = 8'h50;
   localparam logic [7:0]  RCS_ADDR_CTRL   = 8'h58;
   localparam logic [4:0]  RCS_GRP_CNT     = 5'h08;
   localparam logic [4:0]  RCS_GRP_MAT     = 5'h09;
   localparam logic [4:0]  RCS_GRP_MBIT    = 5'h0A;
   localparam logic [4:0]  RCS_GRP_CTRL    = 5'h0B;
   localparam logic [2:0]  RCS_IDX_LAST    = 3'h4;

   localparam logic [7:0]  RCS_CTRL_RESET  = 8'h00;
   localparam int          RCS_B_SOFT_RST  = 7;
   localparam int          RCS_B_CNT_EN    = 6;
   localparam int          RCS_B_WAKE_MAT  = 5;
   localparam int          RCS_B_MODE_HI   = 4;
   localparam int          RCS_B_MODE_LO   = 3;
   localparam int          RCS_B_CLR_MAT   = 2;
   localparam int          RCS_B_CNT_RUN   = 1;
   localparam int          RCS_B_OSC_SEL   = 0;
endpackage

/* logic/rcs_sync2.sv */
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: input is a level from another domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module rcs_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule
`default_nettype wire

/* logic/rcs_rst_sync.sv */
// Purpose: reset bridge, asynchronous assert, release after two edges
// Assumes: arst_n_i may drop at any time
// Notes:   output low while arst_n_i is low
`timescale 1ns/1ns
`default_nettype none
module rcs_rst_sync (
   input  wire logic clk_sys_i,
   input  wire logic arst_n_i,
   output logic      rst_n_o
);
   logic stage;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stage   <= 1'b0;
         rst_n_o <= 1'b0;
      end else begin
         stage   <= 1'b1;
         rst_n_o <= stage;
      end
   end
endmodule
`default_nettype wire

/* logic/rcs_control_status.sv */
// Purpose: timekeeper control/status, prescaler, 40-bit counter, match
// Assumes: crystal_clk_i slow vs clk_sys_i; all access on clk_sys_i
// Notes:   byte access on acm_* ports, read data one cycle after strobe
//
// How it works
// RL1: writing one to control bit 7 resets the timekeeper core; the control register keeps its bits
// RL2: timekeeper state resets asynchronously on supply low or soft reset
// RL3: reset released synchronously two access clock edges later
// RL4: control bit 6 enables counting when not held in reset
// RL5: first advance on 64th crystal edge, then every 128 edges
// RL6: clearing enable resets prescaler, counter value is kept
// RL7: host clears enable before preloading any counter byte
// RL8: bit 5 lets match output follow 40-bit equality, else low
// RL9: control bits 4:3 drive the oscillator mode output
// RL10: for a 32 kHz crystal host programs mode bits to 01
// RL11: bit 2 clears counter on next prescaled edge after match
// RL12: bit 2 zero lets counter run on while matches reported
// RL13: bit 1 zero holds counter at zero, one permits counting
// RL14: bit 0 drives oscillator select output
// RL15: host clears select bit for sleep so fabric stops crystal
// RL16: all control bits are zero while supply indication is low
// RL17: prescaler divides crystal clock by 128
// RL18: match is all 40 per-bit equivalence results true
// RL19: reading low byte captures 40 bits; host reads upper bytes next
// RL20: control reads return held bits, writes act on access clock
`timescale 1ns/1ns
`default_nettype none
module rcs_control_status
   import rcs_pkg::*;
#(
   parameter int CNT_W   = RCS_CNT_W,
   parameter int PRESC_W = RCS_PRESC_W
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       supply_up_flag_i,
   input  wire logic       crystal_clk_i,
   input  wire logic [7:0] acm_addr_i,
   input  wire logic [7:0] acm_wdata_i,
   input  wire logic       acm_wen_i,
   input  wire logic       acm_ren_i,
   output logic      [7:0] acm_rdata_o,
   output logic            match_out_o,
   output logic      [1:0] osc_mode_out_o,
   output logic            osc_select_out_o
);
   logic [7:0]         ctrl;
   logic               supply_up;
   logic               xtal_s;
   logic               xtal_prev;
   logic               xtal_rise;
   logic               core_arst_n;
   logic               core_rst_n;
   logic [PRESC_W-1:0] presc;
   logic               tick;
   logic               running;
   logic [CNT_W-1:0]   count;
   logic [CNT_W-1:0]   match_val;
   logic [CNT_W-1:0]   match_bits;
   logic               match_all;
   logic [CNT_W-1:0]   cap_cnt;
   logic [CNT_W-1:0]   cap_mat;
   logic [CNT_W-1:0]   cap_bits;
   logic [4:0]         grp;
   logic [2:0]         idx;
   logic [5:0]         lane;
   logic               idx_ok;
   logic               wr_cnt;
   logic               wr_mat;
   logic               wr_ctrl;
   logic [7:0]         next_rdata;

   rcs_sync2 #(.W(2)) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({supply_up_flag_i, crystal_clk_i}),
      .sync_o    ({supply_up, xtal_s})
   );

   // soft reset and supply loss both force the core into reset
   assign core_arst_n = rst_n_i & supply_up_flag_i
                        & ~ctrl[RCS_B_SOFT_RST];            // RL1 RL2

   rcs_rst_sync u_core_rst (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (core_arst_n),
      .rst_n_o   (core_rst_n)                               // RL3
   );

   // access decode
   assign grp     = acm_addr_i[7:3];
   assign idx     = acm_addr_i[2:0];
   assign lane    = {idx, 3'h0};
   assign idx_ok  = (idx <= RCS_IDX_LAST);
   assign wr_cnt  = acm_wen_i && grp == RCS_GRP_CNT && idx_ok;
   assign wr_mat  = acm_wen_i && grp == RCS_GRP_MAT && idx_ok;
   assign wr_ctrl = acm_wen_i && acm_addr_i == RCS_ADDR_CTRL;

   // control register: own reset, cleared while supply is low
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= RCS_CTRL_RESET;
      end else if (!supply_up) begin
         ctrl <= RCS_CTRL_RESET;                            // RL16
      end else if (wr_ctrl) begin
         ctrl <= acm_wdata_i;                               // RL20
      end
   end

   // crystal edge detect on synchronised level
   always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         xtal_prev <= 1'b0;
      end else begin
         xtal_prev <= xtal_s;
      end
   end
   assign xtal_rise = xtal_s & ~xtal_prev;

   assign running = ctrl[RCS_B_CNT_EN] & ctrl[RCS_B_CNT_RUN]; // RL4 RL5

   // prescaler counts crystal rising edges, wraps at 128
   always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         presc <= '0;
      end else if (!running) begin
         presc <= '0;                                       // RL6
      end else if (xtal_rise) begin
         presc <= presc + 1'b1;                             // RL17
      end
   end
   // advance on the edge that takes the prescaler past its midpoint
   assign tick = running & xtal_rise
                 & (presc == RCS_PRESC_FIRST[PRESC_W-1:0]); // RL5 RL17

   // per-bit equivalence and full match
   assign match_bits = ~(count ^ match_val);                // RL18
   assign match_all  = &match_bits;                         // RL18

   // 40-bit counter
   always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         count <= '0;                                       // RL2
      end else if (!ctrl[RCS_B_CNT_RUN]) begin
         count <= '0;                                       // RL13
      end else if (wr_cnt) begin
         count[lane +: 8] <= acm_wdata_i;                   // RL7
      end else if (tick) begin
         if (ctrl[RCS_B_CLR_MAT] && match_all) begin
            count <= '0;                                    // RL11
         end else begin
            count <= count + 1'b1;                          // RL12
         end
      end
   end

   // match value register
   always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         match_val <= '0;
      end else if (wr_mat) begin
         match_val[lane +: 8] <= acm_wdata_i;
      end
   end

   // match output gated by wake-on-match bit
   always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         match_out_o <= 1'b0;
      end else begin
         match_out_o <= ctrl[RCS_B_WAKE_MAT] & match_all;   // RL8
      end
   end

   // oscillator mode and select follow control bits
   assign osc_mode_out_o   = ctrl[RCS_B_MODE_HI:RCS_B_MODE_LO]; // RL9
   assign osc_select_out_o = ctrl[RCS_B_OSC_SEL];           // RL14

   // snapshots taken when the low byte of a set is read
   always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         cap_cnt  <= '0;
         cap_mat  <= '0;
         cap_bits <= '0;
      end else if (acm_ren_i) begin
         if (acm_addr_i == RCS_ADDR_CNT0) begin
            cap_cnt <= count;                               // RL19
         end
         if (acm_addr_i == RCS_ADDR_MAT0) begin
            cap_mat <= match_val;                           // RL19
         end
         if (acm_addr_i == RCS_ADDR_MBIT0) begin
            cap_bits <= match_bits;                         // RL19
         end
      end
   end

   // read mux; low byte bypasses the snapshot so it is coherent
   always_comb begin
      next_rdata = 8'h00;
      if (idx_ok) begin
         case (grp)
            RCS_GRP_CNT: begin
               next_rdata = (idx == 3'h0) ? count[7:0] : cap_cnt[lane +: 8];
            end
            RCS_GRP_MAT: begin
               next_rdata = (idx == 3'h0) ? match_val[7:0]
                                          : cap_mat[lane +: 8];
            end
            RCS_GRP_MBIT: begin
               next_rdata = (idx == 3'h0) ? match_bits[7:0]
                                          : cap_bits[lane +: 8];
            end
            RCS_GRP_CTRL: begin
               if (idx == 3'h0) begin
                  next_rdata = ctrl;                        // RL20
               end
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acm_rdata_o <= 8'h00;
      end else if (acm_ren_i) begin
         acm_rdata_o <= next_rdata;
      end
   end
endmodule
`default_nettype wire

/* bench/rcs_xtal_model.sv */
// Purpose: crystal clock source for the timekeeper
// Assumes: 80 ns period, far slower than access clock
// Notes:   clock rests low between bursts
`timescale 1ns/1ns
`default_nettype none
module rcs_xtal_model (
   output var logic crystal_clk_o
);
   initial crystal_clk_o = 1'b0;
   task automatic edges(input int n);
      // keep crystal edges off the access clock edges
      #2;
      repeat (n) begin
         #40 crystal_clk_o = 1'b1;
         #40 crystal_clk_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* bench/rcs_cs_sva.sv */
// Purpose: port assertions for rcs_control_status
// Assumes: access clock only
// Notes:   ctrl_q mirrors control writes
`timescale 1ns/1ns
`default_nettype none
module rcs_cs_sva (
   input wire logic       clk_sys_i,
   input wire logic       rst_n_i,
   input wire logic       supply_up_flag_i,
   input wire logic       crystal_clk_i,
   input wire logic [7:0] acm_addr_i,
   input wire logic [7:0] acm_wdata_i,
   input wire logic       acm_wen_i,
   input wire logic       acm_ren_i,
   input wire logic [7:0] acm_rdata_o,
   input wire logic       match_out_o,
   input wire logic [1:0] osc_mode_out_o,
   input wire logic       osc_select_out_o
);
   logic [7:0] ctrl_q;
   logic [1:0] sup_q;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // supply flag seen through the same two-stage delay as the design
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i)
         sup_q <= 2'b00;
      else
         sup_q <= {sup_q[0], supply_up_flag_i};
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i || !sup_q[1])
         ctrl_q <= 8'h00;
      else if (acm_wen_i && acm_addr_i == 8'h58)
         ctrl_q <= acm_wdata_i;
   end
   sequence s_ctrl_wr;
      supply_up_flag_i [*3] ##0 (acm_wen_i && acm_addr_i == 8'h58);
   endsequence
   a_mode_on_wr: assert property (s_ctrl_wr |=>
      osc_mode_out_o == $past(acm_wdata_i[4:3])) else $error("mode bad");
   a_sel_on_wr: assert property (s_ctrl_wr |=>
      osc_select_out_o == $past(acm_wdata_i[0])) else $error("sel bad");
   a_match_gated: assert property (!ctrl_q[5] && !$past(ctrl_q[5])
      |-> !match_out_o) else $error("match not gated");
   a_unmapped_zero: assert property (acm_ren_i &&
      acm_addr_i == 8'h60 |=> acm_rdata_o == 8'h00) else $error("unmap");
   a_ctrl_rdback: assert property (acm_ren_i && acm_addr_i == 8'h58
      |=> acm_rdata_o[4:3] == osc_mode_out_o
      && acm_rdata_o[0] == osc_select_out_o) else $error("readback");
   a_rdata_hold: assert property (!acm_ren_i |=>
      $stable(acm_rdata_o)) else $error("rdata moved");
   a_soft_hold: assert property (ctrl_q[7] && $past(ctrl_q[7])
      |-> !match_out_o) else $error("match in reset");
   a_supply_clr: assert property (!supply_up_flag_i [*4] |->
      osc_mode_out_o == 2'b00 && !osc_select_out_o) else $error("supply");
endmodule
bind rcs_control_status rcs_cs_sva chk_u (.clk_sys_i, .rst_n_i,
   .supply_up_flag_i, .crystal_clk_i, .acm_addr_i, .acm_wdata_i,
   .acm_wen_i, .acm_ren_i, .acm_rdata_o, .match_out_o,
   .osc_mode_out_o, .osc_select_out_o);
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench for rcs_control_status
// Assumes: crystal edges from rcs_xtal_model
// Notes:   table of control values, then hand tests
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
   error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic        sup       = 1'b1;
   logic        xclk;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdat = 8'h00;
   logic        wen  = 1'b0;
   logic        ren  = 1'b0;
   logic [7:0]  rdat;
   logic        match;
   logic [1:0]  mode;
   logic        sel;
   logic [7:0]  d;
   int          error_cnt = 0;
   int          n_tests   = 0;
   logic [10:0] rows [4] = '{{8'h19, 3'b111}, {8'h08, 3'b010},
                             {8'h11, 3'b101}, {8'h00, 3'b000}};
   always #4 clk_sys_i = ~clk_sys_i;
   rcs_xtal_model xm_u (.crystal_clk_o(xclk));
   rcs_control_status dut_u (
      .clk_sys_i       (clk_sys_i),
      .rst_n_i         (rst_n_i),
      .supply_up_flag_i(sup),
      .crystal_clk_i   (xclk),
      .acm_addr_i      (addr),
      .acm_wdata_i     (wdat),
      .acm_wen_i       (wen),
      .acm_ren_i       (ren),
      .acm_rdata_o     (rdat),
      .match_out_o     (match),
      .osc_mode_out_o  (mode),
      .osc_select_out_o(sel)
   );
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      addr <= a;
      wdat <= v;
      wen  <= 1'b1;
      @(posedge clk_sys_i);
      wen  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      addr <= a;
      ren  <= 1'b1;
      @(posedge clk_sys_i);
      ren  <= 1'b0;
      #1 d = rdat;
   endtask
   // crystal edges, then live count byte
   task automatic cnt(input int n, input logic [7:0] e);
      xm_u.edges(n);
      rd(8'h40);
      `CK("count", e, d)
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      close_out;
   end
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rd(8'h58);
      `CK("ctrl", 8'h00, d)
      foreach (rows[i]) begin
         wr(8'h58, rows[i][10:3]);
         rd(8'h58);
         `CK("ctrl", rows[i][10:3], d)
         `CK("mode", rows[i][2:1], mode)
         `CK("sel", rows[i][0], sel)
      end
      rd(8'h60);
      `CK("unmapped", 8'h00, d)
      $display("table test done");
      wr(8'h48, 8'h03);
      wr(8'h58, 8'h62);
      cnt(63, 8'h00);
      cnt(1, 8'h01);
      cnt(256, 8'h03);
      `CK("match", 1'b1, match)
      cnt(128, 8'h04);
      wr(8'h58, 8'h22);
      wr(8'h48, 8'h05);
      cnt(200, 8'h04);
      wr(8'h58, 8'h62);
      cnt(63, 8'h04);
      cnt(1, 8'h05);
      `CK("match", 1'b1, match)
      wr(8'h58, 8'h66);
      cnt(128, 8'h00);
      cnt(128, 8'h01);
      wr(8'h58, 8'h26);
      wr(8'h41, 8'hA5);
      wr(8'h44, 8'h3C);
      rd(8'h40);
      `CK("cnt0", 8'h01, d)
      wr(8'h41, 8'h11);
      rd(8'h41);
      `CK("cnt1 snap", 8'hA5, d)
      rd(8'h44);
      `CK("cnt4 snap", 8'h3C, d)
      rd(8'h40);
      rd(8'h41);
      `CK("cnt1", 8'h11, d)
      rd(8'h50);
      `CK("mbit0", 8'hFB, d)
      rd(8'h51);
      `CK("mbit1", 8'hEE, d)
      wr(8'h58, 8'h60);
      cnt(0, 8'h00);
      rd(8'h44);
      `CK("held", 8'h00, d)
      $display("count test done");
      wr(8'h58, 8'h80);
      rd(8'h58);
      `CK("ctrl", 8'h80, d)
      rd(8'h48);
      `CK("match reg", 8'h00, d)
      wr(8'h58, 8'h19);
      sup <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      sup <= 1'b1;
      #1 `CK("mode", 2'b00, mode)
      `CK("sel", 1'b0, sel)
      repeat (3) @(posedge clk_sys_i);
      rd(8'h58);
      `CK("ctrl", 8'h00, d)
      $display("reset test done");
      close_out;
   end
endmodule
`default_nettype wire
